// >>> tse_encoder.sv
// tse_encoder: encodes transmission status fields for the platform side
// assumes: condition inputs arrive asynchronously from pins, avalon master on clock
// Function
// - shift pattern status is three bits; 0 default, 1 to 4 patterns one-four.
// - report most recently activated of four pattern switches, not internal pattern.
// - never output the two reserved protection-related pattern codes.
// - when driver deselects pattern switches, output default pattern code.
// - delayed shifts flag active in cold warm-up, else inactive; inactive after reset.
// - delayed shifts flag held inactive when feature unsupported or manual.
// - skip shift true while manual upshift to next gear is inhibited.
// - skip shift false for automatics or manuals without the feature.
// - tap status 1 when switch requests driver shift control and no fault.
// - tap status 2 when switch requests electronic range select and no fault.
// - tap status 0 otherwise; always 0 when neither mode supported or manual.
// - thermal status 1 when operation is altered to reduce heat.
// - thermal status 2 when immediate driver action is needed.
// - thermal status 0 when thermal management absent or manual.
`timescale 1ns/1ps
module tse_encoder (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  pattern_switch_active,
    input  wire logic        warmup_mode,
    input  wire logic        upshift_inhibit,
    input  wire logic [1:0]  tap_enable_request,
    input  wire logic        drv_shift_fault,
    input  wire logic        range_sel_fault,
    input  wire logic        heat_reduction_active,
    input  wire logic        driver_action_needed,
    output logic      [2:0]  shift_pattern_status,
    output logic             shifts_delayed,
    output logic             skip_shift_on,
    output logic      [1:0]  tap_mode_status,
    output logic      [1:0]  thermal_status
);
    tse_pkg::tse_bus_state_type bus_state_r;

    logic [tse_pkg::COND_W-1:0] cond_s;
    logic [tse_pkg::CFG_W-1:0]  cfg_r;
    logic [31:0]                rd_nxt;
    logic [3:0]                 sw_s;
    logic [3:0]                 sw_prev_r;
    logic [3:0]                 sw_rise;
    logic                       sw_desel;
    logic [2:0]                 pat_new;
    logic [2:0]                 pattern_r;
    logic                       warm_s;
    logic                       inhibit_s;
    logic [1:0]                 tapreq_s;
    logic                       sflt_s;
    logic                       rflt_s;
    logic                       heat_s;
    logic                       drv_s;
    logic                       is_manual;
    logic                       delay_ok;
    logic                       skip_ok;
    logic                       drv_ok;
    logic                       rng_ok;
    logic                       therm_ok;
    logic                       delayed_r;
    logic                       skip_r;
    logic [1:0]                 tap_r;
    logic [1:0]                 therm_r;
    logic [1:0]                 tap_nxt;
    logic [1:0]                 therm_nxt;
    logic                       bus_done;

    // all condition pins pass two flops before use
    tse_sync #(
        .W (tse_pkg::COND_W)
    ) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({pattern_switch_active, warmup_mode, upshift_inhibit,
                 tap_enable_request, drv_shift_fault, range_sel_fault,
                 heat_reduction_active, driver_action_needed}),
        .q     (cond_s)
    );

    assign sw_s      = cond_s[11:8];
    assign warm_s    = cond_s[7];
    assign inhibit_s = cond_s[6];
    assign tapreq_s  = cond_s[5:4];
    assign sflt_s    = cond_s[3];
    assign rflt_s    = cond_s[2];
    assign heat_s    = cond_s[1];
    assign drv_s     = cond_s[0];

    assign is_manual = cfg_r[tse_pkg::CFG_MANUAL_BIT];
    assign delay_ok  = cfg_r[tse_pkg::CFG_DELAY_BIT] & ~is_manual;
    assign skip_ok   = cfg_r[tse_pkg::CFG_SKIP_BIT] & is_manual;
    assign drv_ok    = cfg_r[tse_pkg::CFG_DRV_BIT] & ~is_manual;
    assign rng_ok    = cfg_r[tse_pkg::CFG_RNG_BIT] & ~is_manual;
    assign therm_ok  = cfg_r[tse_pkg::CFG_THERM_BIT] & ~is_manual;

    // avalon handshake: one wait cycle, answer in the following cycle
    assign bus_done        = (bus_state_r == tse_pkg::BUS_DONE);
    assign avs_waitrequest = ~bus_done;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            bus_state_r <= tse_pkg::BUS_IDLE;
        end
        else
        begin
            unique case (bus_state_r)
                tse_pkg::BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        bus_state_r <= tse_pkg::BUS_DONE;
                    end
                end
                tse_pkg::BUS_DONE:
                begin
                    bus_state_r <= tse_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // configuration write, only byte lane 0 carries fields
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cfg_r <= tse_pkg::CFG_RST;
        end
        else if (bus_done && avs_write && avs_address == tse_pkg::ADDR_CFG
                 && avs_byteenable[0])
        begin
            cfg_r <= avs_writedata[tse_pkg::CFG_W-1:0];
        end
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        rd_nxt = 32'h0;
        unique case (avs_address)
            tse_pkg::ADDR_CFG:
            begin
                rd_nxt[tse_pkg::CFG_W-1:0] = cfg_r;
            end
            tse_pkg::ADDR_STAT:
            begin
                rd_nxt[tse_pkg::STAT_PAT_LSB +: 3]   = pattern_r;
                rd_nxt[tse_pkg::STAT_DELAY_BIT]      = delayed_r;
                rd_nxt[tse_pkg::STAT_SKIP_BIT]       = skip_r;
                rd_nxt[tse_pkg::STAT_TAP_LSB +: 2]   = tap_r;
                rd_nxt[tse_pkg::STAT_THERM_LSB +: 2] = therm_r;
            end
            tse_pkg::ADDR_COND:
            begin
                rd_nxt[tse_pkg::COND_W-1:0] = cond_s;
            end
            default:
            begin
                rd_nxt = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            avs_readdata <= 32'h0;
        end
        else if (!bus_done && avs_read)
        begin
            avs_readdata <= rd_nxt;
        end
    end

    // shift pattern tracking
    assign sw_rise  = sw_s & ~sw_prev_r;
    assign sw_desel = (sw_prev_r != 4'h0) && (sw_s == 4'h0);

    // lowest switch wins when several rise together; codes stay in 1..4
    always_comb
    begin
        pat_new = tse_pkg::PAT_DEFAULT;
        for (int i = 3; i >= 0; i--)
        begin
            if (sw_rise[i])
            begin
                pat_new = 3'(i + 1);
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sw_prev_r <= 4'h0;
        end
        else
        begin
            sw_prev_r <= sw_s;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pattern_r <= tse_pkg::PAT_DEFAULT;
        end
        else if (sw_rise != 4'h0)
        begin
            pattern_r <= pat_new;
        end
        else if (sw_desel)
        begin
            pattern_r <= tse_pkg::PAT_DEFAULT;
        end
    end

    // single-bit flags
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            delayed_r <= 1'b0;
            skip_r    <= 1'b0;
        end
        else
        begin
            delayed_r <= warm_s & delay_ok;
            skip_r    <= inhibit_s & skip_ok;
        end
    end

    // tap mode selection
    always_comb
    begin
        tap_nxt = tse_pkg::TAP_NONE;
        if (drv_ok && tapreq_s == tse_pkg::TAPREQ_DRV && !sflt_s)
        begin
            tap_nxt = tse_pkg::TAP_DRV;
        end
        else if (rng_ok && tapreq_s == tse_pkg::TAPREQ_RNG && !rflt_s)
        begin
            tap_nxt = tse_pkg::TAP_RNG;
        end
    end

    // thermal management; driver intervention outranks countermeasures
    always_comb
    begin
        therm_nxt = tse_pkg::THERM_NORMAL;
        if (therm_ok && drv_s)
        begin
            therm_nxt = tse_pkg::THERM_INTERV;
        end
        else if (therm_ok && heat_s)
        begin
            therm_nxt = tse_pkg::THERM_CM;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tap_r   <= tse_pkg::TAP_NONE;
            therm_r <= tse_pkg::THERM_NORMAL;
        end
        else
        begin
            tap_r   <= tap_nxt;
            therm_r <= therm_nxt;
        end
    end

    assign shift_pattern_status = pattern_r;
    assign shifts_delayed       = delayed_r;
    assign skip_shift_on        = skip_r;
    assign tap_mode_status      = tap_r;
    assign thermal_status       = therm_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_PAT_RANGE: assert property (
        shift_pattern_status <= tse_pkg::PAT_LAST)
        else $error("pattern code out of range");

    AST_PAT_NO_RSV: assert property (
        shift_pattern_status != tse_pkg::PAT_RSV_NONPROT
        && shift_pattern_status != tse_pkg::PAT_RSV_PROT)
        else $error("reserved pattern code output");

    AST_PAT_LATEST: assert property (
        (sw_s == 4'h4 && sw_prev_r == 4'h0) |=> shift_pattern_status == 3'h3)
        else $error("switch 3 activation not reported");

    AST_PAT_DESEL: assert property (
        $fell(|sw_s) |-> ##1 shift_pattern_status == tse_pkg::PAT_DEFAULT)
        else $error("deselection did not give default pattern");

    AST_PAT_HOLD: assert property (
        (sw_s == sw_prev_r) |=> $stable(shift_pattern_status))
        else $error("pattern changed without switch event");

    AST_RESET_DEFAULTS: assert property (
        @(posedge clock) disable iff (1'b0) !rst_n |=> !shifts_delayed
        && shift_pattern_status == tse_pkg::PAT_DEFAULT)
        else $error("reset values wrong");

    AST_DELAY_ON: assert property (
        (warm_s && delay_ok) |=> shifts_delayed)
        else $error("delayed shifts not active in warm-up");

    AST_DELAY_OFF: assert property (
        (!cfg_r[tse_pkg::CFG_DELAY_BIT] || is_manual) |=> !shifts_delayed)
        else $error("delayed shifts active while unsupported");

    AST_SKIP_ON: assert property (
        (inhibit_s && skip_ok) |=> skip_shift_on)
        else $error("skip shift not indicated");

    AST_SKIP_OFF: assert property (
        (!is_manual || !cfg_r[tse_pkg::CFG_SKIP_BIT]) |=> !skip_shift_on)
        else $error("skip shift true while unsupported");

    AST_TAP_DRV: assert property (
        (drv_ok && tapreq_s == tse_pkg::TAPREQ_DRV && !sflt_s)
        |=> tap_mode_status == tse_pkg::TAP_DRV)
        else $error("driver shift control not reported");

    AST_TAP_RNG: assert property (
        (rng_ok && tapreq_s == tse_pkg::TAPREQ_RNG && !rflt_s)
        |=> tap_mode_status == tse_pkg::TAP_RNG)
        else $error("range select not reported");

    AST_TAP_NONE: assert property (
        (is_manual || (tapreq_s == tse_pkg::TAPREQ_DRV && sflt_s))
        |=> tap_mode_status == tse_pkg::TAP_NONE)
        else $error("tap mode active when it must not be");

    AST_THERM_CM: assert property (
        (therm_ok && heat_s && !drv_s) |=> thermal_status == tse_pkg::THERM_CM)
        else $error("countermeasures not reported");

    AST_THERM_INT: assert property (
        (therm_ok && drv_s) |=> thermal_status == tse_pkg::THERM_INTERV)
        else $error("driver intervention not reported");

    AST_THERM_OFF: assert property (
        !therm_ok |=> thermal_status == tse_pkg::THERM_NORMAL)
        else $error("thermal status not normal while unsupported");

    AST_BUS_ANSWER: assert property (
        ((avs_read || avs_write) && !bus_done) |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");

    COV_PAT_FOUR: cover property (shift_pattern_status == 3'h4);
    COV_TAP_RNG: cover property (tap_mode_status == tse_pkg::TAP_RNG);
    COV_THERM_INT: cover property (thermal_status == tse_pkg::THERM_INTERV);
    COV_BUS_READ: cover property (avs_read && !avs_waitrequest);
endmodule : tse_encoder

// >>> tse_pkg.sv
// tse_pkg: shared constants for the transmission status encoder
// assumes: byte-addressed avalon-mm slave, 32-bit data, one word per register
package tse_pkg;
    // register byte offsets
    localparam logic [3:0]  ADDR_CFG        = 4'h0;
    localparam logic [3:0]  ADDR_STAT       = 4'h4;
    localparam logic [3:0]  ADDR_COND       = 4'h8;
    // configuration field positions and reset value
    localparam int          CFG_W           = 6;
    localparam int          CFG_MANUAL_BIT  = 0;
    localparam int          CFG_DELAY_BIT   = 1;
    localparam int          CFG_SKIP_BIT    = 2;
    localparam int          CFG_DRV_BIT     = 3;
    localparam int          CFG_RNG_BIT     = 4;
    localparam int          CFG_THERM_BIT   = 5;
    localparam logic [5:0]  CFG_RST         = 6'h00;
    // status word field positions
    localparam int          STAT_PAT_LSB    = 0;
    localparam int          STAT_DELAY_BIT  = 3;
    localparam int          STAT_SKIP_BIT   = 4;
    localparam int          STAT_TAP_LSB    = 5;
    localparam int          STAT_THERM_LSB  = 7;
    // width of the synchronised condition vector
    localparam int          COND_W          = 12;
    // shift pattern codes
    localparam logic [2:0]  PAT_DEFAULT     = 3'h0;
    localparam logic [2:0]  PAT_LAST        = 3'h4;
    localparam logic [2:0]  PAT_RSV_NONPROT = 3'h5;
    localparam logic [2:0]  PAT_RSV_PROT    = 3'h6;
    // tap mode codes and enable switch request codes
    localparam logic [1:0]  TAP_NONE        = 2'h0;
    localparam logic [1:0]  TAP_DRV         = 2'h1;
    localparam logic [1:0]  TAP_RNG         = 2'h2;
    localparam logic [1:0]  TAPREQ_DRV      = 2'h1;
    localparam logic [1:0]  TAPREQ_RNG      = 2'h2;
    // thermal management codes
    localparam logic [1:0]  THERM_NORMAL    = 2'h0;
    localparam logic [1:0]  THERM_CM        = 2'h1;
    localparam logic [1:0]  THERM_INTERV    = 2'h2;
    // bus handshake states
    typedef enum logic {
        BUS_IDLE,
        BUS_DONE
    } tse_bus_state_type;
endpackage : tse_pkg

// >>> tse_sync.sv
// tse_sync: two-flop synchroniser for a vector of slow levels
// assumes: each bit is an independent level, no bus coherence needed
`timescale 1ns/1ps
module tse_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : tse_sync

// >>> tse_platform_model.sv
// tse_platform_model: receiving platform side of the transmission status fields
// assumes: status outputs of tse_encoder on the same clock, link_ok from the bench
`timescale 1ns/1ps
module tse_platform_model #(
    parameter int BULB_CYCLES = 8
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       link_ok,
    input  wire logic [2:0] shift_pattern_status,
    input  wire logic       skip_shift_on,
    input  wire logic [1:0] tap_mode_status,
    output logic      [2:0] pattern_seen,
    output logic            skip_lamp,
    output logic      [1:0] tap_display
);
    logic [3:0] bulb_cnt_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            bulb_cnt_r <= 4'h0;
        else if (bulb_cnt_r < BULB_CYCLES)
            bulb_cnt_r <= bulb_cnt_r + 4'h1;
    end

    // lamp lit through the bulb check after reset, then follows the indication
    always_ff @(posedge clock)
    begin
        skip_lamp <= (bulb_cnt_r < BULB_CYCLES) | skip_shift_on;
    end

    // displays take a new value one cycle after it arrives
    always_ff @(posedge clock)
    begin
        tap_display <= tap_mode_status;
    end

    always_ff @(posedge clock)
    begin
        pattern_seen <= link_ok ? shift_pattern_status : 3'h0;
    end
endmodule : tse_platform_model

// >>> transmission_status_encoder_test.sv
// transmission_status_encoder_test: bus-driven checks of the status encoder
// assumes: tse_encoder with one wait cycle per access, status 3 edges after inputs
`timescale 1ns/1ps
module transmission_status_encoder_test;
    logic        clock;
    logic        rst_n;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [3:0]  sw;
    logic        warmup_mode;
    logic        upshift_inhibit;
    logic [1:0]  tap_req;
    logic        drv_fault;
    logic        rng_fault;
    logic        heat;
    logic        act;
    logic [2:0]  shift_pattern_status;
    logic        shifts_delayed;
    logic        skip_shift_on;
    logic [1:0]  tap_mode_status;
    logic [1:0]  thermal_status;
    logic        link_ok;
    logic [2:0]  pattern_seen;
    logic        skip_lamp;
    logic [1:0]  tap_display;
    logic [5:0]  cfg_v;
    logic [2:0]  exp_pat;
    logic [31:0] rd;
    int          num_errors;
    int          samples_checked;
    int          cycle_cnt;

    tse_encoder tse_encoder_inst (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pattern_switch_active(sw),
        .warmup_mode(warmup_mode), .upshift_inhibit(upshift_inhibit),
        .tap_enable_request(tap_req), .drv_shift_fault(drv_fault),
        .range_sel_fault(rng_fault),
        .heat_reduction_active(heat), .driver_action_needed(act),
        .shift_pattern_status(shift_pattern_status), .shifts_delayed(shifts_delayed),
        .skip_shift_on(skip_shift_on), .tap_mode_status(tap_mode_status),
        .thermal_status(thermal_status));

    tse_platform_model tse_platform_model_inst (.clock(clock), .rst_n(rst_n),
        .link_ok(link_ok), .shift_pattern_status(shift_pattern_status),
        .skip_shift_on(skip_shift_on), .tap_mode_status(tap_mode_status),
        .pattern_seen(pattern_seen), .skip_lamp(skip_lamp), .tap_display(tap_display));

    always #5 clock = ~clock;

    task complete_run;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    always @(posedge clock)
    begin
        cycle_cnt++;
        if (cycle_cnt == 20000)
        begin
            num_errors++;
            complete_run();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task bus_rw(input logic wr, input logic [3:0] a, input logic [31:0] d,
                input logic [3:0] be);
        @(posedge clock);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= ~wr;
        avs_write      <= wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_rw

    task settle;
        repeat (4) @(posedge clock);
    endtask : settle

    task set_cfg(input logic [5:0] c);
        cfg_v = c;
        bus_rw(1'b1, tse_pkg::ADDR_CFG, {26'h0, c}, 4'hf);
        settle();
    endtask : set_cfg

    task set_sw(input logic [3:0] s);
        sw <= s;
        settle();
    endtask : set_sw

    function automatic logic [31:0] exp_word();
        logic       d;
        logic       s;
        logic [1:0] t;
        logic [1:0] h;
        d = cfg_v[1] & ~cfg_v[0] & warmup_mode;
        s = cfg_v[0] & cfg_v[2] & upshift_inhibit;
        t = tse_pkg::TAP_NONE;
        if (!cfg_v[0] && tap_req == 2'h1 && cfg_v[3] && !drv_fault)
            t = tse_pkg::TAP_DRV;
        if (!cfg_v[0] && tap_req == 2'h2 && cfg_v[4] && !rng_fault)
            t = tse_pkg::TAP_RNG;
        h = tse_pkg::THERM_NORMAL;
        if (cfg_v[5] && !cfg_v[0])
            h = act ? tse_pkg::THERM_INTERV : (heat ? tse_pkg::THERM_CM : 2'h0);
        return {23'h0, h, t, s, d, exp_pat};
    endfunction : exp_word

    // compares the status word both on the bus and at the pins
    task check_status;
        bus_rw(1'b0, tse_pkg::ADDR_STAT, 32'h0, 4'hf);
        chk(rd, exp_word());
        chk({23'h0, thermal_status, tap_mode_status, skip_shift_on, shifts_delayed,
             shift_pattern_status}, exp_word());
        rd = exp_word();
        chk({30'h0, tap_display}, {30'h0, rd[6:5]});
    endtask : check_status

    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
        {sw, warmup_mode, upshift_inhibit, tap_req, drv_fault, rng_fault, heat, act} = '0;
        link_ok = 1'b1;
        cfg_v = 6'h00;
        exp_pat = 3'h0;
        num_errors = 0;
        samples_checked = 0;
        cycle_cnt = 0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk({31'h0, skip_lamp}, 32'h1);
        check_status();
        bus_rw(1'b0, tse_pkg::ADDR_CFG, 32'h0, 4'hf);
        chk(rd, 32'h0);
        bus_rw(1'b0, 4'hc, 32'h0, 4'hf);
        chk(rd, 32'h0);
        set_cfg(6'h3a);
        bus_rw(1'b0, tse_pkg::ADDR_CFG, 32'h0, 4'hf);
        chk(rd, 32'h3a);
        set_sw(4'h4);
        exp_pat = 3'h3;
        check_status();
        set_sw(4'h5);
        exp_pat = 3'h1;
        check_status();
        set_sw(4'h4);
        check_status();
        set_sw(4'h0);
        exp_pat = 3'h0;
        check_status();
        set_sw(4'ha);
        exp_pat = 3'h2;
        check_status();
        set_sw(4'h0);
        exp_pat = 3'h0;
        for (int k = 0; k < 4; k++)
        begin
            set_sw(4'h1 << k);
            exp_pat = 3'(k + 1);
            check_status();
            chk({29'h0, pattern_seen}, {29'h0, exp_pat});
            link_ok <= 1'b0;
            settle();
            chk({29'h0, pattern_seen}, 32'h0);
            link_ok <= 1'b1;
            set_sw(4'h0);
            exp_pat = 3'h0;
        end
        warmup_mode <= 1'b1;
        settle();
        check_status();
        set_cfg(6'h38);
        check_status();
        set_cfg(6'h3a);
        for (int i = 0; i < 16; i++)
        begin
            {tap_req, drv_fault, rng_fault} <= 4'(i);
            settle();
            check_status();
        end
        for (int i = 0; i < 4; i++)
        begin
            {heat, act} <= 2'(i);
            settle();
            check_status();
        end
        tap_req <= 2'h1;
        drv_fault <= 1'b0;
        set_cfg(6'h3b);
        check_status();
        set_cfg(6'h1a);
        check_status();
        upshift_inhibit <= 1'b1;
        set_cfg(6'h05);
        check_status();
        chk({31'h0, skip_lamp}, 32'h1);
        set_cfg(6'h04);
        check_status();
        chk({31'h0, skip_lamp}, 32'h0);
        set_cfg(6'h01);
        check_status();
        bus_rw(1'b1, tse_pkg::ADDR_STAT, 32'hffffffff, 4'hf);
        bus_rw(1'b1, tse_pkg::ADDR_CFG, 32'h3f, 4'he);
        bus_rw(1'b0, tse_pkg::ADDR_CFG, 32'h0, 4'hf);
        chk(rd, {26'h0, cfg_v});
        set_cfg(6'h3a);
        set_sw(4'h2);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        @(posedge clock);
        chk({23'h0, thermal_status, tap_mode_status, skip_shift_on, shifts_delayed,
             shift_pattern_status}, 32'h0);
        chk({31'h0, skip_lamp}, 32'h1);
        bus_rw(1'b0, tse_pkg::ADDR_CFG, 32'h0, 4'hf);
        chk(rd, 32'h0);
        complete_run();
    end
endmodule : transmission_status_encoder_test
